// ---- rtl/adc_conversion_control.sv ----
`timescale 1ns/100ps
`include "adc_conversion_control_regs.svh"

// Overview of operation
// - Open-sensor bit enables source and sink currents
// - Buffer enable bit switches input buffer
// - Analog clock is oscillator over divider plus one
// - Eight power-of-two gains, 1 to 128
// - Offset trim: sign bit, seven magnitude bits
// - Calibration select; seven conversions per pass
// - Calibration done raises converter interrupt flag
// - Filter fast, sinc2, sinc3 or automatic
// - Auto: two fast, then sinc2, then sinc3
// - Reference internal or external; internal 2.5V default
// - Internal reference level 1.25V or 2.5V
// - Any pin pair selectable as differential input
// - All-ones selector enables temperature diodes; mux pos and neg still both 15
module adc_conversion_control
  import adc_conversion_control_pkg::*;
#(
  parameter int DEC_W = 11
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic [7:0]       i_sfr_addr,
  input  wire logic             i_sfr_wr,
  input  wire logic             i_sfr_rd,
  input  wire logic [7:0]       i_sfr_wdata,
  output logic      [7:0]       o_sfr_rdata,
  input  wire logic [7:0]       i_mux_select,
  input  wire logic [DEC_W-1:0] i_decimation_ratio,
  output logic                  o_open_sensor_source,
  output logic                  o_open_sensor_sink,
  output logic                  o_buffer_en,
  output logic      [2:0]       o_gain_sel,
  output logic                  o_trim_sign,
  output logic      [6:0]       o_trim_magnitude,
  output logic                  o_vref_internal,
  output logic                  o_vref_high,
  output logic                  o_aclk_en,
  output logic                  o_mod_clk_en,
  output logic                  o_conv_done,
  output logic      [1:0]       o_filter_sel,
  output logic                  o_discard,
  output logic                  o_cal_busy,
  output logic      [2:0]       o_cal_mode,
  output logic                  o_adc_irq,
  output logic      [3:0]       o_mux_pos,
  output logic      [3:0]       o_mux_neg,
  output logic                  o_temp_diode_en
);

  initial begin
    if (DEC_W < 2 || DEC_W > 16) $error("adc_conversion_control: DEC_W out of range");
  end

  sfr_byte_t        ctrl_main, next_ctrl_main;
  logic [1:0]       filter_mode, next_filter_mode;
  logic [2:0]       cal_select, next_cal_select;
  sfr_byte_t        trim, next_trim;
  sfr_byte_t        aclk_div, next_aclk_div;
  sfr_byte_t        next_rdata;
  cal_state_t       cal_state, next_cal_state;
  logic [3:0]       cal_count, next_cal_count;
  logic [3:0]       cal_len, next_cal_len;
  logic             irq_flag, next_irq_flag;
  logic [1:0]       auto_count, next_auto_count;
  logic [7:0]       mux_q;
  logic [2:0]       gain_q;
  logic [1:0]       next_filter_sel;
  logic             wr_main, wr_cal, wr_trim, wr_aclk;
  logic             cal_finish, input_changed, next_discard;
  logic             aclk_tick, mod_tick, conv_tick;
  logic [DEC_W-1:0] conv_terminal;

  assign wr_main = i_sfr_wr && (i_sfr_addr == `ADC_CTRL_MAIN_OFF);
  assign wr_cal  = i_sfr_wr && (i_sfr_addr == `ADC_CTRL_CAL_OFF);
  assign wr_trim = i_sfr_wr && (i_sfr_addr == `INPUT_OFFSET_TRIM_OFF);
  assign wr_aclk = i_sfr_wr && (i_sfr_addr == `ANALOG_CLOCK_DIV_OFF);

  // Rate chain: oscillator -> analog clock -> modulator -> conversions
  rate_enable_divider #(.W (8)) u_aclk_div (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_en       (1'b1),
    .i_terminal (aclk_div),
    .o_tick     (aclk_tick)
  );
  rate_enable_divider #(.W (8)) u_mod_div (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_en       (aclk_tick),
    .i_terminal (8'(`MOD_CLOCK_DIV - 1)),
    .o_tick     (mod_tick)
  );
  // A zero ratio is served as a ratio of one
  assign conv_terminal = (i_decimation_ratio == '0) ? '0 : i_decimation_ratio - DEC_W'(1);
  rate_enable_divider #(.W (DEC_W)) u_conv_div (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_en       (mod_tick),
    .i_terminal (conv_terminal),
    .o_tick     (conv_tick)
  );

  // Register writes and read data
  always_comb begin
    next_ctrl_main   = ctrl_main;
    next_filter_mode = filter_mode;
    next_trim        = trim;
    next_aclk_div    = aclk_div;
    next_rdata       = o_sfr_rdata;
    if (wr_main) begin
      next_ctrl_main = i_sfr_wdata & 8'h7F;
    end
    if (wr_cal) begin
      next_filter_mode = i_sfr_wdata[`CAL_FILTER_MSB:`CAL_FILTER_LSB];
    end
    if (wr_trim) begin
      next_trim = i_sfr_wdata;
    end
    if (wr_aclk) begin
      next_aclk_div = i_sfr_wdata;
    end
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        `ADC_CTRL_MAIN_OFF:     next_rdata = ctrl_main;
        `ADC_CTRL_CAL_OFF:      next_rdata = {irq_flag, (cal_state == CAL_RUN), filter_mode,
                                              1'b0, cal_select};
        `INPUT_OFFSET_TRIM_OFF: next_rdata = trim;
        `ANALOG_CLOCK_DIV_OFF:  next_rdata = aclk_div;
        default:                next_rdata = `SFR_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_main   <= `ADC_CTRL_MAIN_RST;
      filter_mode <= `FILTER_AUTO;
      trim        <= `INPUT_OFFSET_TRIM_RST;
      aclk_div    <= `ANALOG_CLOCK_DIV_RST;
      o_sfr_rdata <= `SFR_UNMAPPED_READ;
    end else begin
      ctrl_main   <= next_ctrl_main;
      filter_mode <= next_filter_mode;
      trim        <= next_trim;
      aclk_div    <= next_aclk_div;
      o_sfr_rdata <= next_rdata;
    end
  end

  // Calibration sequencing
  assign cal_finish = (cal_state == CAL_RUN) && conv_tick && (cal_count + 4'h1 == cal_len);

  always_comb begin
    next_cal_state  = cal_state;
    next_cal_count  = cal_count;
    next_cal_len    = cal_len;
    next_cal_select = cal_select;
    next_irq_flag   = irq_flag;
    if (cal_state == CAL_RUN && conv_tick) begin
      next_cal_count = cal_count + 4'h1;
    end
    if (cal_finish) begin
      next_cal_state  = CAL_IDLE;
      next_cal_select = `CAL_NONE;
    end
    if (wr_cal) begin
      next_irq_flag   = 1'b0;
      next_cal_select = i_sfr_wdata[`CAL_SELECT_MSB:`CAL_SELECT_LSB];
      next_cal_count  = 4'h0;
      unique case (i_sfr_wdata[`CAL_SELECT_MSB:`CAL_SELECT_LSB])
        `CAL_SELF_BOTH: begin
          next_cal_state = CAL_RUN;
          next_cal_len   = `CAL_BOTH_CONVERSIONS;
        end
        `CAL_SELF_OFFSET, `CAL_SELF_GAIN, `CAL_SYS_OFFSET, `CAL_SYS_GAIN: begin
          next_cal_state = CAL_RUN;
          next_cal_len   = `CAL_PASS_CONVERSIONS;
        end
        default: begin
          next_cal_state  = CAL_IDLE;
          next_cal_select = `CAL_NONE;
        end
      endcase
    end
    if (cal_finish) begin
      next_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cal_state  <= CAL_IDLE;
      cal_count  <= 4'h0;
      cal_len    <= `CAL_PASS_CONVERSIONS;
      cal_select <= `CAL_NONE;
      irq_flag   <= 1'b0;
    end else begin
      cal_state  <= next_cal_state;
      cal_count  <= next_cal_count;
      cal_len    <= next_cal_len;
      cal_select <= next_cal_select;
      irq_flag   <= next_irq_flag;
    end
  end

  // Filter selection and automatic switching
  assign input_changed = (i_mux_select != mux_q) ||
                         (ctrl_main[`MAIN_GAIN_MSB:`MAIN_GAIN_LSB] != gain_q);

  always_comb begin
    next_auto_count = auto_count;
    if (input_changed) begin
      next_auto_count = 2'h0;
    end else if (conv_tick && auto_count != `AUTO_SINC3_COUNT) begin
      next_auto_count = auto_count + 2'h1;
    end
    next_discard = 1'b0;
    if (filter_mode != `FILTER_AUTO) begin
      next_filter_sel = filter_mode;
    end else if (next_auto_count < `AUTO_SINC2_COUNT) begin
      next_filter_sel = `FILTER_FAST;
      next_discard    = (next_auto_count == 2'h0);
    end else if (next_auto_count == `AUTO_SINC2_COUNT) begin
      next_filter_sel = `FILTER_SINC2;
    end else begin
      next_filter_sel = `FILTER_SINC3;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      auto_count   <= 2'h0;
      mux_q        <= 8'h00;
      gain_q       <= 3'h0;
      o_filter_sel <= `FILTER_FAST;
      o_discard    <= 1'b1;
    end else begin
      auto_count   <= next_auto_count;
      mux_q        <= i_mux_select;
      gain_q       <= ctrl_main[`MAIN_GAIN_MSB:`MAIN_GAIN_LSB];
      o_filter_sel <= next_filter_sel;
      o_discard    <= next_discard;
    end
  end

  // Registered analog control outputs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_open_sensor_source <= 1'b0;
      o_open_sensor_sink   <= 1'b0;
      o_buffer_en          <= 1'b0;
      o_gain_sel           <= 3'h0;
      o_trim_sign          <= 1'b0;
      o_trim_magnitude     <= 7'h00;
      o_vref_internal      <= 1'b1;
      o_vref_high          <= 1'b1;
      o_aclk_en            <= 1'b0;
      o_mod_clk_en         <= 1'b0;
      o_conv_done          <= 1'b0;
      o_cal_busy           <= 1'b0;
      o_cal_mode           <= `CAL_NONE;
      o_adc_irq            <= 1'b0;
      o_mux_pos            <= 4'h0;
      o_mux_neg            <= 4'h0;
      o_temp_diode_en      <= 1'b0;
    end else begin
      o_open_sensor_source <= next_ctrl_main[`MAIN_OPEN_SENSOR_BIT];
      o_open_sensor_sink   <= next_ctrl_main[`MAIN_OPEN_SENSOR_BIT];
      o_buffer_en          <= next_ctrl_main[`MAIN_BUFFER_BIT];
      o_gain_sel           <= next_ctrl_main[`MAIN_GAIN_MSB:`MAIN_GAIN_LSB];
      o_trim_sign          <= next_trim[7];
      o_trim_magnitude     <= next_trim[6:0];
      o_vref_internal      <= next_ctrl_main[`MAIN_VREF_ON_BIT];
      o_vref_high          <= next_ctrl_main[`MAIN_VREF_HIGH_BIT];
      o_aclk_en            <= aclk_tick;
      o_mod_clk_en         <= mod_tick;
      o_conv_done          <= conv_tick;
      o_cal_busy           <= (next_cal_state == CAL_RUN);
      o_cal_mode           <= next_cal_select;
      o_adc_irq            <= next_irq_flag;
      o_mux_pos            <= i_mux_select[7:4];
      o_mux_neg            <= i_mux_select[3:0];
      o_temp_diode_en      <= (i_mux_select == `TEMP_DIODE_SELECT);
    end
  end

endmodule

// ---- rtl/adc_conversion_control_regs.svh ----
`ifndef ADC_CONVERSION_CONTROL_REGS_SVH
`define ADC_CONVERSION_CONTROL_REGS_SVH

// Register addresses on the special-function register port
`define ADC_CTRL_MAIN_OFF       8'hDC
`define ADC_CTRL_CAL_OFF        8'hDD
`define INPUT_OFFSET_TRIM_OFF   8'hE6
`define ANALOG_CLOCK_DIV_OFF    8'hF6

// adc_ctrl_main fields
`define MAIN_OPEN_SENSOR_BIT    6
`define MAIN_VREF_ON_BIT        5
`define MAIN_VREF_HIGH_BIT      4
`define MAIN_BUFFER_BIT         3
`define MAIN_GAIN_MSB           2
`define MAIN_GAIN_LSB           0

// adc_ctrl_cal fields
`define CAL_IRQ_BIT             7
`define CAL_BUSY_BIT            6
`define CAL_FILTER_MSB          5
`define CAL_FILTER_LSB          4
`define CAL_SELECT_MSB          2
`define CAL_SELECT_LSB          0

// Reset values: internal reference on, 2.5 V level
`define ADC_CTRL_MAIN_RST       8'h30
`define ADC_CTRL_CAL_RST        8'h00
`define INPUT_OFFSET_TRIM_RST   8'h00
`define ANALOG_CLOCK_DIV_RST    8'h00

// Filter codes
`define FILTER_AUTO             2'h0
`define FILTER_FAST             2'h1
`define FILTER_SINC2            2'h2
`define FILTER_SINC3            2'h3

// Calibration select codes
`define CAL_NONE                3'h0
`define CAL_SELF_BOTH           3'h1
`define CAL_SELF_OFFSET         3'h2
`define CAL_SELF_GAIN           3'h3
`define CAL_SYS_OFFSET          3'h4
`define CAL_SYS_GAIN            3'h5

// Timing counts
`define MOD_CLOCK_DIV           64
`define CAL_PASS_CONVERSIONS    4'h7
`define CAL_BOTH_CONVERSIONS    4'hE
`define AUTO_SINC2_COUNT        2'h2
`define AUTO_SINC3_COUNT        2'h3
`define TEMP_DIODE_SELECT       8'hFF
`define SFR_UNMAPPED_READ       8'h00

`endif

// ---- rtl/adc_conversion_control_pkg.sv ----
package adc_conversion_control_pkg;

  typedef enum logic [0:0] {
    CAL_IDLE,
    CAL_RUN
  } cal_state_t;

  typedef logic [7:0] sfr_byte_t;

endpackage

// ---- rtl/rate_enable_divider.sv ----
`timescale 1ns/100ps

module rate_enable_divider #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_terminal,
  output logic              o_tick
);

  initial begin
    if (W < 1) begin
      $error("rate_enable_divider: W must be at least 1");
    end
  end

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_tick;

  // One tick per i_terminal+1 enabled cycles
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (i_en) begin
      if (count >= i_terminal) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      count  <= next_count;
      o_tick <= next_tick;
    end
  end

endmodule

// ---- verification/adc_conversion_control_monitor.sv ----
`timescale 1ns/100ps
module adc_conversion_control_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] i_mux_select,
  input wire logic       o_open_sensor_source,
  input wire logic       o_open_sensor_sink,
  input wire logic       o_buffer_en,
  input wire logic [2:0] o_gain_sel,
  input wire logic       o_trim_sign,
  input wire logic [6:0] o_trim_magnitude,
  input wire logic       o_vref_internal,
  input wire logic       o_vref_high,
  input wire logic       o_aclk_en,
  input wire logic       o_mod_clk_en,
  input wire logic       o_conv_done,
  input wire logic       o_cal_busy,
  input wire logic [2:0] o_cal_mode,
  input wire logic       o_adc_irq,
  input wire logic [3:0] o_mux_pos,
  input wire logic [3:0] o_mux_neg,
  input wire logic       o_temp_diode_en
);
  logic       cal_wr;
  logic       busy_q;
  logic [6:0] aclk_cnt, next_aclk_cnt;
  logic       mod_seen, next_mod_seen;
  logic [3:0] conv_cnt, next_conv_cnt;
  logic [3:0] cal_len, next_cal_len;
  assign cal_wr = i_sfr_wr && i_sfr_addr == 8'hdd;
  always_comb begin
    // Pulse seen with a modulator pulse is the first of the next group
    next_aclk_cnt = (o_mod_clk_en ? 7'h0 : aclk_cnt) + 7'(o_aclk_en);
    next_mod_seen = mod_seen | o_mod_clk_en;
    // A conversion counts if calibration ran while it was produced
    next_conv_cnt = cal_wr ? 4'h0 : conv_cnt + 4'(o_conv_done && busy_q);
    next_cal_len  = !cal_wr ? cal_len : (i_sfr_wdata[2:0] == 3'h1) ? 4'he : 4'h7;
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      aclk_cnt <= 7'h0;
      mod_seen <= 1'b0;
      conv_cnt <= 4'h0;
      cal_len  <= 4'h7;
      busy_q   <= 1'b0;
    end else begin
      busy_q   <= o_cal_busy;
      aclk_cnt <= next_aclk_cnt;
      mod_seen <= next_mod_seen;
      conv_cnt <= next_conv_cnt;
      cal_len  <= next_cal_len;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence main_wr; i_sfr_wr && i_sfr_addr == 8'hdc; endsequence
  sequence cal_start; cal_wr && i_sfr_wdata[2:0] inside {[3'h1:3'h5]}; endsequence
  sequence cal_end; $fell(o_cal_busy) && !$past(cal_wr); endsequence
  open_sensor_a: assert property (main_wr |=> o_open_sensor_source ==
    $past(i_sfr_wdata[6]) && o_open_sensor_sink == $past(i_sfr_wdata[6]))
    else $error("open sensor enables wrong");
  buffer_en_a: assert property (main_wr |=> o_buffer_en == $past(i_sfr_wdata[3]))
    else $error("buffer enable wrong");
  gain_sel_a: assert property (main_wr |=> o_gain_sel == $past(i_sfr_wdata[2:0]))
    else $error("gain select wrong");
  vref_sel_a: assert property (main_wr |=> o_vref_internal ==
    $past(i_sfr_wdata[5]) && o_vref_high == $past(i_sfr_wdata[4]))
    else $error("reference select wrong");
  trim_out_a: assert property (i_sfr_wr && i_sfr_addr == 8'he6 |=>
    {o_trim_sign, o_trim_magnitude} == $past(i_sfr_wdata)) else $error("trim wrong");
  mod_rate_a: assert property (o_mod_clk_en && mod_seen |->
    aclk_cnt == 7'h40) else $error("modulator rate wrong");
  cal_start_a: assert property (cal_start |=> o_cal_busy && !o_adc_irq &&
    o_cal_mode == $past(i_sfr_wdata[2:0])) else $error("calibration start wrong");
  cal_length_a: assert property (cal_end |-> conv_cnt == cal_len - 4'h1)
    else $error("calibration length wrong");
  cal_done_a: assert property (cal_end |-> o_adc_irq && o_conv_done &&
    o_cal_mode == 3'h0) else $error("calibration done flag wrong");
  mux_copy_a: assert property (1'b1 |=>
    {o_mux_pos, o_mux_neg} == $past(i_mux_select)) else $error("selector copy wrong");
  temp_diode_a: assert property (1'b1 |=>
    o_temp_diode_en == ($past(i_mux_select) == 8'hff)) else $error("temp diode wrong");
endmodule

bind adc_conversion_control adc_conversion_control_monitor i_mon (.i_mclk, .i_rstn,
  .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_mux_select, .o_open_sensor_source,
  .o_open_sensor_sink, .o_buffer_en, .o_gain_sel, .o_trim_sign, .o_trim_magnitude,
  .o_vref_internal, .o_vref_high, .o_aclk_en, .o_mod_clk_en, .o_conv_done,
  .o_cal_busy, .o_cal_mode, .o_adc_irq, .o_mux_pos, .o_mux_neg, .o_temp_diode_en);

// ---- verification/analog_front_end_model.sv ----
`timescale 1ns/100ps
module analog_front_end_model (
  input  wire logic [2:0] i_cal_mode,
  input  wire logic       i_open_sensor_source,
  input  wire logic       i_sensor_open,
  output logic      [7:0] o_diff_level
);
  always_comb begin
    if (i_cal_mode == 3'h4) begin
      o_diff_level = 8'h00;
    end else if (i_cal_mode == 3'h5) begin
      o_diff_level = 8'h7f;
    end else if (i_open_sensor_source && i_sensor_open) begin
      o_diff_level = 8'h7f;
    end else begin
      o_diff_level = 8'h20;
    end
  end
endmodule

// ---- verification/test_adc_conversion_control.sv ----
`timescale 1ns/100ps
module test_adc_conversion_control;
  logic i_mclk, i_rstn, i_sfr_wr, i_sfr_rd;
  logic [7:0] i_sfr_addr, i_sfr_wdata, i_mux_select, o_sfr_rdata, afe_level;
  logic [10:0] i_decimation_ratio;
  logic o_open_sensor_source, o_open_sensor_sink, o_buffer_en, o_trim_sign;
  logic o_vref_internal, o_vref_high, o_aclk_en, o_mod_clk_en, o_conv_done;
  logic o_discard, o_cal_busy, o_adc_irq, o_temp_diode_en;
  logic [2:0] o_gain_sel, o_cal_mode;
  logic [6:0] o_trim_magnitude;
  logic [1:0] o_filter_sel;
  logic [3:0] o_mux_pos, o_mux_neg;
  int miscompares, checked;
  adc_conversion_control i_adc_conversion_control (.i_mclk, .i_rstn, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .i_mux_select, .i_decimation_ratio,
    .o_open_sensor_source, .o_open_sensor_sink, .o_buffer_en, .o_gain_sel, .o_trim_sign,
    .o_trim_magnitude, .o_vref_internal, .o_vref_high, .o_aclk_en, .o_mod_clk_en,
    .o_conv_done, .o_filter_sel, .o_discard, .o_cal_busy, .o_cal_mode, .o_adc_irq,
    .o_mux_pos, .o_mux_neg, .o_temp_diode_en);
  analog_front_end_model i_analog_front_end_model (.i_cal_mode(o_cal_mode),
    .i_open_sensor_source(o_open_sensor_source), .i_sensor_open(i_mux_select[7]),
    .o_diff_level(afe_level));
  always #10 i_mclk = ~i_mclk;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick;
    @(posedge i_mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_mclk);
    i_sfr_wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_mclk);
    i_sfr_rd <= 1'b0;
    #1;
    check(o_sfr_rdata, exp);
  endtask
  task wait_pulse(input bit conv, output int n);
    n = 0;
    do begin
      tick;
      n++;
    end while ((conv ? o_conv_done : o_aclk_en) !== 1'b1 && n < 400);
    if (n >= 400) miscompares++;
  endtask
  task t_reset;
    check(o_vref_internal, 8'h01);
    check(o_vref_high, 8'h01);
    rchk(8'hdc, 8'h30);
    rchk(8'hdd, 8'h00);
    rchk(8'he6, 8'h00);
    rchk(8'hf6, 8'h00);
    rchk(8'h80, 8'h00);
  endtask
  task t_main;
    logic [7:0] d;
    for (int g = 0; g < 8; g++) begin
      d = {1'b1, g[0], g[1], g[2], ~g[0], g[2:0]};
      wr(8'hdc, d);
      check(o_open_sensor_source, d[6]);
      check(o_open_sensor_sink, d[6]);
      check(o_vref_internal, d[5]);
      check(o_vref_high, d[4]);
      check(o_buffer_en, d[3]);
      check(o_gain_sel, d[2:0]);
      rchk(8'hdc, {1'b0, d[6:0]});
    end
    wr(8'hdc, 8'h30);
  endtask
  task t_trim;
    logic [7:0] v[3] = '{8'ha5, 8'h7f, 8'h80};
    foreach (v[i]) begin
      wr(8'he6, v[i]);
      check(o_trim_sign, v[i][7]);
      check(o_trim_magnitude, v[i][6:0]);
      rchk(8'he6, v[i]);
    end
  endtask
  task t_rate;
    int n;
    wr(8'hf6, 8'h02);
    wait_pulse(0, n);
    wait_pulse(0, n);
    check(8'(n), 8'h03);
    wr(8'hf6, 8'h00);
    wait_pulse(1, n);
    wait_pulse(1, n);
    check(8'(n), 8'h80);
  endtask
  task t_filter;
    int n;
    for (int f = 1; f < 4; f++) begin
      wr(8'hdd, 8'(f << 4));
      tick;
      check(o_filter_sel, 8'(f));
    end
    wr(8'hdd, 8'h00);
    wait_pulse(1, n);
    @(posedge i_mclk);
    i_mux_select <= 8'h12;
    tick;
    tick;
    check(o_filter_sel, 8'h01);
    check(o_discard, 8'h01);
    check({o_mux_pos, o_mux_neg}, 8'h12);
    for (int k = 0; k < 3; k++) begin
      wait_pulse(1, n);
      tick;
      check(o_filter_sel, k == 0 ? 8'h01 : 8'(k + 1));
      check(o_discard, 8'h00);
    end
    wr(8'hdc, 8'h31);
    tick;
    check(o_filter_sel, 8'h01);
    @(posedge i_mclk);
    i_mux_select <= 8'hff;
    tick;
    tick;
    check(o_temp_diode_en, 8'h01);
  endtask
  task t_cal;
    int n, k;
    for (int m = 1; m < 6; m++) begin
      wr(8'hdd, 8'(m));
      check(o_cal_busy, 8'h01);
      check(o_cal_mode, 8'(m));
      if (m > 3) check(afe_level, m == 4 ? 8'h00 : 8'h7f);
      n = 0;
      k = 0;
      do begin
        tick;
        k++;
        if (o_conv_done === 1'b1) n++;
      end while (o_cal_busy === 1'b1 && k < 4000);
      if (k >= 4000) miscompares++;
      check(8'(n), m == 1 ? 8'h0e : 8'h07);
      check(o_adc_irq, 8'h01);
      check(o_conv_done, 8'h01);
      rchk(8'hdd, 8'h80);
    end
    wr(8'he6, 8'h05);
    wr(8'hdd, 8'h02);
    check(o_adc_irq, 8'h00);
    wr(8'hdd, 8'h07);
    check(o_cal_busy, 8'h00);
    check(o_cal_mode, 8'h00);
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end
  initial begin
    {i_mclk, i_rstn, i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata, i_mux_select} = '0;
    i_decimation_ratio = 11'h002;
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    tick;
    t_reset;
    t_main;
    t_trim;
    t_rate;
    t_filter;
    t_cal;
    finish_test;
  end
endmodule
